// >>> core/gripper_status_register_bank.sv
// Status register bank of a two-finger gripper controller.
//
// Overview of operation
// - Activation echo mirrors activation request; 0 while it is clear, 1 while it is set, including during activation.
// - Go-to echo mirrors go-to request; 0 while stopped, activating or releasing.
// - Gripper state reads 0 reset/release, 1 activating, 3 activated; never 2.
// - Object status: 0 moving, 1 contact opening, 2 contact closing, 3 at target.
// - Fault code 0 none, 5 command before activation done, 7 command unactivated.
// - Blue for none or priority fault, red for minor, blinking for major.
// - Fault 8 at 85 C or more, cleared only below 80 C.
// - Fault 9 after one second without any received command.
// - Major faults stay latched until activation request is cleared with no major cause present.
// - Major codes A undervoltage, B release, C internal, D activation, E overcurrent, F released.
// - Target echo byte returns the last written target position.
// - Measured position byte reports encoder finger position, 0 open to FF closed.
// - Motor current byte is sampled from the motor drive each cycle.
// - Force request zero disables re-grasp; any nonzero force enables it.
// - Fault byte holds external controller fault high, gripper fault code low.
// - Clearing activation request resets the gripper and clears a latched major fault code when no major cause is present.
// - Object status returns to in-motion when finger motion is detected with no contact or at-target flag.
`timescale 1ns/10ps
module gripper_status_register_bank #(
   parameter int COMM_TIMEOUT = gripper_status_pkg::COMM_TIMEOUT_CYCLES,
   parameter int BLINK_HALF = gripper_status_pkg::BLINK_HALF_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input gripper_status_pkg::command_t command,
   input wire logic commandStrobe,
   input gripper_status_pkg::plant_t plant,
   input wire logic [3:0] regAddr,
   output logic [7:0] regData,
   output logic ledRed,
   output logic ledBlue,
   output logic regraspEnable
);
   import gripper_status_pkg::*;

   gripper_state_t gripperState, next_gripperState;
   logic activationEcho, next_activationEcho;
   logic gotoEcho, next_gotoEcho;
   logic activationPrev, next_activationPrev;
   logic [1:0] objectStatus, next_objectStatus;
   logic [3:0] majorCode, next_majorCode;
   logic [3:0] priorityCode, next_priorityCode;
   logic tempHot, next_tempHot;
   logic commLost, next_commLost;
   logic [25:0] commCount, next_commCount;
   logic [24:0] blinkCount, next_blinkCount;
   logic blinkPhase, next_blinkPhase;
   logic [7:0] targetEcho, next_targetEcho;
   logic [7:0] measuredPosition, next_measuredPosition;
   logic [7:0] motorCurrent, next_motorCurrent;
   logic [7:0] next_regData;
   logic next_ledRed, next_ledBlue, next_regraspEnable;
   logic [3:0] faultCode;
   logic [3:0] majorEvent;
   logic activationRise;

   assign activationRise = command.activationRequest & ~activationPrev;

   // Only the first major cause is kept, except that any later cause replaces a running release.
   always_comb begin
      majorEvent = FLT_NONE;
      if (plant.internalFault) begin
         majorEvent = FLT_INTERNAL;
      end else if (plant.underVoltage) begin
         majorEvent = FLT_UNDER_VOLTAGE;
      end else if (plant.overCurrent) begin
         majorEvent = FLT_OVER_CURRENT;
      end else if (gripperState == ST_ACTIVATING && plant.activationFailed) begin
         majorEvent = FLT_ACTIVATION;
      end else if (plant.releaseDone) begin
         majorEvent = FLT_RELEASE_DONE;
      end else if (plant.releaseRunning) begin
         majorEvent = FLT_RELEASE_RUN;
      end
   end

   always_comb begin
      next_activationPrev = command.activationRequest;
      next_activationEcho = command.activationRequest;
      next_gotoEcho = command.activationRequest & command.gotoRequest & (gripperState == ST_ACTIVE)
                      & ~plant.releaseRunning;
      next_majorCode = majorCode;
      if (majorEvent != FLT_NONE && (majorCode == FLT_NONE || majorCode == FLT_RELEASE_RUN)) begin
         next_majorCode = majorEvent;
      end else if (!command.activationRequest && majorEvent == FLT_NONE) begin
         next_majorCode = FLT_NONE;
      end
      next_gripperState = gripperState;
      case (gripperState)
         ST_RESET: begin
            if (activationRise && majorEvent == FLT_NONE) begin
               next_gripperState = ST_ACTIVATING;
            end
         end
         ST_ACTIVATING: begin
            if (plant.activationDone) begin
               next_gripperState = ST_ACTIVE;
            end
         end
         default: begin
            next_gripperState = gripperState;
         end
      endcase
      if (!command.activationRequest || majorEvent != FLT_NONE || majorCode != FLT_NONE) begin
         next_gripperState = ST_RESET;
      end
   end

   always_comb begin
      next_priorityCode = priorityCode;
      if (commandStrobe && command.gotoRequest) begin
         if (!command.activationRequest) begin
            next_priorityCode = FLT_NOT_ACTIVATED;
         end else if (gripperState != ST_ACTIVE) begin
            next_priorityCode = FLT_ACTION_DELAYED;
         end else begin
            next_priorityCode = FLT_NONE;
         end
      end
      next_tempHot = tempHot;
      if (plant.temperature >= TEMP_HOT_C) begin
         next_tempHot = 1'b1;
      end else if (plant.temperature < TEMP_COOL_C) begin
         next_tempHot = 1'b0;
      end
      next_commCount = commCount;
      next_commLost = commLost;
      if (commandStrobe) begin
         next_commCount = '0;
         next_commLost = 1'b0;
      end else if (commCount >= 26'(COMM_TIMEOUT - 1)) begin
         next_commLost = 1'b1;
      end else begin
         next_commCount = commCount + 26'h1;
      end
   end

   always_comb begin
      if (majorCode != FLT_NONE) begin
         faultCode = majorCode;
      end else if (tempHot) begin
         faultCode = FLT_OVER_TEMP;
      end else if (commLost) begin
         faultCode = FLT_COMM_LOST;
      end else begin
         faultCode = priorityCode;
      end
   end

   always_comb begin
      next_objectStatus = objectStatus;
      if (plant.contactOpening) begin
         next_objectStatus = OBJ_CONTACT_OPEN;
      end else if (plant.contactClosing) begin
         next_objectStatus = OBJ_CONTACT_CLOSE;
      end else if (plant.atTarget) begin
         next_objectStatus = OBJ_AT_TARGET;
      end else if (plant.motionDetected) begin
         next_objectStatus = OBJ_MOVING;
      end
      if (!command.activationRequest) begin
         next_objectStatus = OBJ_MOVING;
      end
      next_targetEcho = commandStrobe ? command.targetPosition : targetEcho;
      next_measuredPosition = plant.measuredPosition;
      next_motorCurrent = plant.motorCurrent;
      next_regraspEnable = (command.forceRequest != RESET_BYTE);
      next_blinkCount = blinkCount + 25'h1;
      next_blinkPhase = blinkPhase;
      if (blinkCount >= 25'(BLINK_HALF - 1)) begin
         next_blinkCount = '0;
         next_blinkPhase = ~blinkPhase;
      end
      if (faultCode >= FLT_MAJOR_MIN) begin
         next_ledRed = blinkPhase;
         next_ledBlue = ~blinkPhase;
      end else if (faultCode == FLT_OVER_TEMP || faultCode == FLT_COMM_LOST) begin
         next_ledRed = 1'b1;
         next_ledBlue = 1'b0;
      end else begin
         next_ledRed = 1'b0;
         next_ledBlue = 1'b1;
      end
   end

   // Read data is registered, so it answers one cycle after the address.
   always_comb begin
      if (regAddr == ADDR_MOTION_STATE) begin
         next_regData = {objectStatus, gripperState, gotoEcho, 2'b00, activationEcho};
      end else if (regAddr == ADDR_FAULT_CODE) begin
         next_regData = {plant.externalControllerFault, faultCode};
      end else if (regAddr == ADDR_TARGET_ECHO) begin
         next_regData = targetEcho;
      end else if (regAddr == ADDR_MEASURED_POS) begin
         next_regData = measuredPosition;
      end else if (regAddr == ADDR_MOTOR_CURRENT) begin
         next_regData = motorCurrent;
      end else begin
         next_regData = RESET_BYTE;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gripperState <= ST_RESET;
         activationEcho <= 1'b0;
         gotoEcho <= 1'b0;
         activationPrev <= 1'b0;
         objectStatus <= OBJ_MOVING;
         majorCode <= FLT_NONE;
         priorityCode <= FLT_NONE;
         tempHot <= 1'b0;
         commLost <= 1'b0;
         commCount <= '0;
         blinkCount <= '0;
         blinkPhase <= 1'b0;
         targetEcho <= RESET_BYTE;
         measuredPosition <= RESET_BYTE;
         motorCurrent <= RESET_BYTE;
         regData <= RESET_BYTE;
         ledRed <= 1'b0;
         ledBlue <= 1'b1;
         regraspEnable <= 1'b0;
      end else begin
         gripperState <= next_gripperState;
         activationEcho <= next_activationEcho;
         gotoEcho <= next_gotoEcho;
         activationPrev <= next_activationPrev;
         objectStatus <= next_objectStatus;
         majorCode <= next_majorCode;
         priorityCode <= next_priorityCode;
         tempHot <= next_tempHot;
         commLost <= next_commLost;
         commCount <= next_commCount;
         blinkCount <= next_blinkCount;
         blinkPhase <= next_blinkPhase;
         targetEcho <= next_targetEcho;
         measuredPosition <= next_measuredPosition;
         motorCurrent <= next_motorCurrent;
         regData <= next_regData;
         ledRed <= next_ledRed;
         ledBlue <= next_ledBlue;
         regraspEnable <= next_regraspEnable;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_major_set;
      majorEvent != FLT_NONE && majorCode == FLT_NONE;
   endsequence
   sequence s_held_active;
      command.activationRequest [*2];
   endsequence

   a_act_echo: assert property (##1 activationEcho == $past(command.activationRequest))
      else $error("activation echo does not follow request");
   a_goto_idle: assert property (gripperState != ST_ACTIVE |=> !gotoEcho)
      else $error("go-to echo set outside activated state");
   a_state_code: assert property (gripperState != ST_UNUSED)
      else $error("unused gripper state code produced");
   a_obj_contact: assert property (command.activationRequest && plant.contactClosing && !plant.contactOpening
                                   |=> objectStatus == OBJ_CONTACT_CLOSE)
      else $error("closing contact not reported");
   a_prio_unact: assert property (commandStrobe && command.gotoRequest && !command.activationRequest
                                  |=> priorityCode == FLT_NOT_ACTIVATED)
      else $error("command while unactivated not flagged");
   a_temp_hyst: assert property (tempHot && plant.temperature >= TEMP_COOL_C |=> tempHot)
      else $error("temperature fault cleared above cool threshold");
   a_comm_clear: assert property (commandStrobe |=> !commLost ##1 (commandStrobe || !commLost))
      else $error("communication fault with recent command");
   a_major_hold: assert property (s_major_set ##1 s_held_active |-> majorCode != FLT_NONE)
      else $error("major fault dropped while activation held");
   a_major_reset: assert property (majorCode != FLT_NONE |=> gripperState == ST_RESET)
      else $error("gripper left reset with major fault");
   a_target_echo: assert property (commandStrobe |=> targetEcho == $past(command.targetPosition))
      else $error("target echo not updated");
   a_regrasp_sel: assert property (##1 regraspEnable == ($past(command.forceRequest) != RESET_BYTE))
      else $error("re-grasp select wrong");
   a_act_clear: assert property (!command.activationRequest && majorEvent == FLT_NONE
                                 |=> majorCode == FLT_NONE)
      else $error("fault not cleared with activation low");
   // A fault cause that is still present wins over a clear in the same cycle.
   a_major_set: assert property (majorEvent != FLT_NONE |=> majorCode != FLT_NONE)
      else $error("major fault event not latched");
endmodule

// >>> core/gripper_status_pkg.sv
// Constants, codes and carrier types for the gripper status register bank.
package gripper_status_pkg;
   // Register byte offsets.
   localparam logic [3:0] ADDR_MOTION_STATE = 4'h0;
   localparam logic [3:0] ADDR_RESERVED = 4'h1;
   localparam logic [3:0] ADDR_FAULT_CODE = 4'h2;
   localparam logic [3:0] ADDR_TARGET_ECHO = 4'h3;
   localparam logic [3:0] ADDR_MEASURED_POS = 4'h4;
   localparam logic [3:0] ADDR_MOTOR_CURRENT = 4'h5;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Object status codes.
   localparam logic [1:0] OBJ_MOVING = 2'h0;
   localparam logic [1:0] OBJ_CONTACT_OPEN = 2'h1;
   localparam logic [1:0] OBJ_CONTACT_CLOSE = 2'h2;
   localparam logic [1:0] OBJ_AT_TARGET = 2'h3;
   // Fault codes.
   localparam logic [3:0] FLT_NONE = 4'h0;
   localparam logic [3:0] FLT_ACTION_DELAYED = 4'h5;
   localparam logic [3:0] FLT_NOT_ACTIVATED = 4'h7;
   localparam logic [3:0] FLT_OVER_TEMP = 4'h8;
   localparam logic [3:0] FLT_COMM_LOST = 4'h9;
   localparam logic [3:0] FLT_UNDER_VOLTAGE = 4'hA;
   localparam logic [3:0] FLT_RELEASE_RUN = 4'hB;
   localparam logic [3:0] FLT_INTERNAL = 4'hC;
   localparam logic [3:0] FLT_ACTIVATION = 4'hD;
   localparam logic [3:0] FLT_OVER_CURRENT = 4'hE;
   localparam logic [3:0] FLT_RELEASE_DONE = 4'hF;
   localparam logic [3:0] FLT_MAJOR_MIN = 4'hA;
   // Temperature thresholds in degrees Celsius.
   localparam logic [7:0] TEMP_HOT_C = 8'h55;
   localparam logic [7:0] TEMP_COOL_C = 8'h50;
   // Timing.
   localparam int CLK_HZ = 50_000_000;
   localparam int COMM_TIMEOUT_MS = 1000;
   localparam int COMM_TIMEOUT_CYCLES = CLK_HZ / 1000 * COMM_TIMEOUT_MS;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_ACTIVATING = 2'b01,
      ST_UNUSED = 2'b10,
      ST_ACTIVE = 2'b11
   } gripper_state_t;

   typedef struct packed {
      logic activationRequest;
      logic gotoRequest;
      logic [7:0] targetPosition;
      logic [7:0] speedRequest;
      logic [7:0] forceRequest;
   } command_t;

   typedef struct packed {
      logic motionDetected;
      logic contactOpening;
      logic contactClosing;
      logic atTarget;
      logic activationDone;
      logic activationFailed;
      logic underVoltage;
      logic internalFault;
      logic overCurrent;
      logic releaseRunning;
      logic releaseDone;
      logic [7:0] temperature;
      logic [7:0] measuredPosition;
      logic [7:0] motorCurrent;
      logic [3:0] externalControllerFault;
   } plant_t;
endpackage

// >>> test/plc_model.sv
// Controller model that writes command frames to the gripper status bank.
`timescale 1ns/10ps
module plc_model (
   input wire logic clk,
   output gripper_status_pkg::command_t command,
   output logic commandStrobe
);
   import gripper_status_pkg::*;
   initial begin
      command = '0;
      commandStrobe = 1'b0;
   end
   // one whole frame per call
   // Target, speed and force go out in the same frame as the go-to bit.
   // Recovery is a frame with activation clear followed by one with it set.
   task automatic send(input logic act, input logic go, input logic [7:0] pos, input logic [7:0] frc);
      @(negedge clk);
      command.activationRequest = act;
      command.gotoRequest = go;
      command.targetPosition = pos;
      command.speedRequest = 8'h80;
      command.forceRequest = frc;
      commandStrobe = 1'b1;
      @(negedge clk);
      commandStrobe = 1'b0;
   endtask
endmodule

// >>> test/gripper_status_register_bank_tb.sv
// Self-checking testbench for the gripper status register bank.
`timescale 1ns/10ps
module gripper_status_register_bank_tb;
   import gripper_status_pkg::*;
   localparam int TMO = 200;
   localparam logic [3:0] EXT = 4'h6;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   command_t command;
   logic commandStrobe;
   plant_t plant = '0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regData;
   logic ledRed;
   logic ledBlue;
   logic regraspEnable;
   int n_errors = 0;
   int comparisons = 0;

   always #10 clk = ~clk;

   gripper_status_register_bank #(.COMM_TIMEOUT(TMO), .BLINK_HALF(4)) i_dut (
      .clk(clk), .rstn(rstn), .command(command), .commandStrobe(commandStrobe), .plant(plant),
      .regAddr(regAddr), .regData(regData), .ledRed(ledRed), .ledBlue(ledBlue), .regraspEnable(regraspEnable)
   );
   plc_model i_plc (.clk(clk), .command(command), .commandStrobe(commandStrobe));

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(negedge clk) regAddr = a;
      @(negedge clk) chk($sformatf("reg%0h", a), exp, regData);
   endtask

   task automatic settle();
      repeat (3) @(negedge clk);
   endtask

   task automatic end_sim();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic t_reset();
      repeat (6) @(negedge clk);
      chk("ledBlue", 8'h01, {7'h0, ledBlue});
      chk("ledRed", 8'h00, {7'h0, ledRed});
      rstn = 1'b1;
      // Reserved and unmapped addresses must read zero as well.
      for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
   endtask

   task automatic t_priority();
      i_plc.send(1'b0, 1'b1, 8'h10, 8'h00);
      settle();
      rd(ADDR_FAULT_CODE, {4'h0, FLT_NOT_ACTIVATED});
      chk("ledBlue", 8'h01, {7'h0, ledBlue});
      i_plc.send(1'b1, 1'b0, 8'h10, 8'h00);
      settle();
      rd(ADDR_MOTION_STATE, 8'h11);
      i_plc.send(1'b1, 1'b1, 8'h10, 8'h00);
      settle();
      rd(ADDR_FAULT_CODE, {4'h0, FLT_ACTION_DELAYED});
      plant.activationDone = 1'b1;
      settle();
      rd(ADDR_MOTION_STATE, 8'h39);
      i_plc.send(1'b1, 1'b1, 8'h10, 8'h00);
      settle();
      rd(ADDR_FAULT_CODE, {4'h0, FLT_NONE});
   endtask

   task automatic t_object();
      logic [7:0] exp [4] = '{8'h79, 8'hB9, 8'hF9, 8'h39};
      for (int k = 0; k < 4; k++) begin
         plant.contactOpening = (k == 0);
         plant.contactClosing = (k == 1);
         plant.atTarget = (k == 2);
         plant.motionDetected = (k == 3);
         settle();
         rd(ADDR_MOTION_STATE, exp[k]);
      end
      plant.motionDetected = 1'b0;
   endtask

   task automatic t_data();
      logic [7:0] frc [3] = '{8'h00, 8'h01, 8'hFF};
      plant.externalControllerFault = EXT;
      plant.measuredPosition = 8'h3C;
      plant.motorCurrent = 8'hC3;
      for (int k = 0; k < 3; k++) begin
         i_plc.send(1'b1, 1'b1, 8'hA5 ^ frc[k], frc[k]);
         settle();
         chk("regrasp", {7'h0, k != 0}, {7'h0, regraspEnable});
         rd(ADDR_TARGET_ECHO, 8'hA5 ^ frc[k]);
      end
      rd(ADDR_MEASURED_POS, 8'h3C);
      rd(ADDR_MOTOR_CURRENT, 8'hC3);
      rd(ADDR_FAULT_CODE, {EXT, FLT_NONE});
   endtask

   task automatic t_temp();
      logic [7:0] temp [3] = '{8'd85, 8'd80, 8'd79};
      for (int k = 0; k < 3; k++) begin
         plant.temperature = temp[k];
         settle();
         rd(ADDR_FAULT_CODE, {EXT, (k < 2) ? FLT_OVER_TEMP : FLT_NONE});
         chk("ledRed", {7'h0, k < 2}, {7'h0, ledRed});
      end
   endtask

   task automatic t_comm();
      i_plc.send(1'b1, 1'b1, 8'h20, 8'h01);
      repeat (TMO - 5) @(negedge clk);
      rd(ADDR_FAULT_CODE, {EXT, FLT_NONE});
      repeat (10) @(negedge clk);
      rd(ADDR_FAULT_CODE, {EXT, FLT_COMM_LOST});
      chk("ledRed", 8'h01, {7'h0, ledRed});
      i_plc.send(1'b1, 1'b1, 8'h20, 8'h01);
      settle();
      rd(ADDR_FAULT_CODE, {EXT, FLT_NONE});
   endtask

   task automatic setmaj(input int k, input logic v);
      case (k)
         0: plant.underVoltage = v;
         1: plant.releaseRunning = v;
         2: plant.internalFault = v;
         3: plant.activationFailed = v;
         4: plant.overCurrent = v;
         default: plant.releaseDone = v;
      endcase
   endtask

   task automatic t_major(input int k, input logic [3:0] code);
      int r;
      int b;
      int eq;
      r = 0;
      b = 0;
      eq = 0;
      i_plc.send(1'b0, 1'b0, 8'h20, 8'h01);
      settle();
      rd(ADDR_FAULT_CODE, {EXT, FLT_NONE});
      plant.activationDone = 1'b0;
      i_plc.send(1'b1, 1'b0, 8'h20, 8'h01);
      settle();
      @(negedge clk) setmaj(k, 1'b1);
      @(negedge clk) setmaj(k, 1'b0);
      settle();
      rd(ADDR_FAULT_CODE, {EXT, code});
      rd(ADDR_MOTION_STATE, 8'h01);
      // Both colours must show and never together while a major fault blinks.
      repeat (12) @(negedge clk) begin
         r += (ledRed === 1'b1);
         b += (ledBlue === 1'b1);
         eq += (ledRed === ledBlue);
      end
      chk("blink", 8'h07, {5'h0, r > 0, b > 0, eq == 0});
   endtask

   initial begin
      t_reset();
      t_priority();
      t_object();
      t_data();
      t_temp();
      t_comm();
      t_major(0, FLT_UNDER_VOLTAGE);
      t_major(1, FLT_RELEASE_RUN);
      t_major(2, FLT_INTERNAL);
      t_major(3, FLT_ACTIVATION);
      t_major(4, FLT_OVER_CURRENT);
      t_major(5, FLT_RELEASE_DONE);
      end_sim();
   end

   // The whole sequence needs well under a few thousand cycles.
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end
endmodule
